// ---- src/tsf_pkg.sv ----
/*
 * Package of the tape synchronizer function decoder: APB register map,
 * function code layout, status bit positions, reset values, states and
 * the structs that carry the tape handler pins.
 * Assumes a 200 MHz pclk and a tape handler whose pins are asynchronous.
 */
// Contract
// - Middle octal digit selects unit, units 0-3
// - Binary odd parity, coded even parity
// - 1X02 selects status one, 1X03 status two
// - 1X04 sets interrupt lockout, 1X05 clears it
// - 1X07 clears synchronizer back to idle
// - 1X10-1X13 write; bit0 density, bit1 coded
// - 1X14 writes a file mark
// - 1X20 searches forward, 1X21 backward, to mark
// - 1X22 rewinds to load point, 1X26 unloads
// - 1X24 one record forward, 1X25 backward
// - 1X30-1X33 read with mode, 1X34 plain read
// - Status one bits 0-3: coded, not ready, parity, program
// - Status one bits 4-7: EOF, tape mark, density, busy
// - Illegal BCD sets status one bits 0,2,3
// - Status two bits 0-6 as listed
package tsf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FUNC = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_STAT1 = 8'h08;
	localparam logic [7:0] ADDR_STAT2 = 8'h0C;
	localparam logic [7:0] ADDR_UNIT = 8'h10;
	localparam logic [7:0] ADDR_STATE = 8'h14;

	// ----------------------------------------------------------------
	// Function code layout: group digit, unit digit, operation digits
	// ----------------------------------------------------------------
	localparam int GROUP_LSB = 9;
	localparam int UNIT_LSB = 6;
	localparam logic [2:0] GROUP_TAPE = 3'h1;
	localparam logic [2:0] UNIT_MAX = 3'h3;
	localparam logic [5:0] OP_STAT1 = 6'h02;
	localparam logic [5:0] OP_STAT2 = 6'h03;
	localparam logic [5:0] OP_LOCK_SET = 6'h04;
	localparam logic [5:0] OP_LOCK_CLR = 6'h05;
	localparam logic [5:0] OP_CLEAR = 6'h07;
	localparam logic [3:0] OP_WRITE_HI = 4'h2;
	localparam logic [5:0] OP_MARK = 6'h0C;
	localparam logic [5:0] OP_SRCH_FWD = 6'h10;
	localparam logic [5:0] OP_SRCH_BACK = 6'h11;
	localparam logic [5:0] OP_REWIND = 6'h12;
	localparam logic [5:0] OP_REC_FWD = 6'h14;
	localparam logic [5:0] OP_REC_BACK = 6'h15;
	localparam logic [5:0] OP_UNLOAD = 6'h16;
	localparam logic [3:0] OP_READ_HI = 4'h6;
	localparam logic [5:0] OP_READ_KEEP = 6'h1C;
	localparam int MODE_DENS_BIT = 0;
	localparam int MODE_CODED_BIT = 1;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int S1_CODED = 0;
	localparam int S1_NOT_READY = 1;
	localparam int S1_PARITY = 2;
	localparam int S1_PROGRAM = 3;
	localparam int S1_EOF = 4;
	localparam int S1_TAPE_MARK = 5;
	localparam int S1_HIGH_DENS = 6;
	localparam int S1_BUSY = 7;
	localparam int S2_HIGH_DENS = 0;
	localparam int S2_EVEN = 1;
	localparam int S2_EOF = 2;
	localparam int S2_LOAD_POINT = 3;
	localparam int S2_WR_NOT_READY = 4;
	localparam int S2_SEARCHING = 5;
	localparam int S2_WR_MARK = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] UNIT_RESET = 2'h0;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic CODED_RESET = 1'b0;
	localparam logic DENS_RESET = 1'b0;
	localparam logic [5:0] BCD_ILLEGAL = 6'h00;

	// Source of the word returned by a data read
	typedef enum logic [1:0] {
		TSF_SRC_DATA = 2'h0,
		TSF_SRC_STAT1 = 2'h1,
		TSF_SRC_STAT2 = 2'h2
	} tsf_src_e;

	// Gray coded along idle -> write -> read -> move -> mark
	typedef enum logic [2:0] {
		TSF_IDLE = 3'h0,
		TSF_WRITE = 3'h1,
		TSF_READ = 3'h3,
		TSF_MOVE = 3'h2,
		TSF_MARK = 3'h6
	} tsf_state_e;

	typedef struct packed {
		logic ready;
		logic load_point;
		logic end_tape;
		logic file_mark;
		logic rec_gap;
		logic write_ring;
		logic char_strobe;
		logic [6:0] rd_char;
	} tsf_tape_in_s;

	typedef struct packed {
		logic fwd;
		logic rev;
		logic write;
		logic rewind;
		logic unload;
		logic mark;
		logic high_density;
		logic even_parity;
		logic wr_valid;
		logic [6:0] wr_char;
	} tsf_tape_out_s;

endpackage : tsf_pkg

// ---- src/tsf_sync.sv ----
/*
 * Two flip-flop synchronizer for a group of level signals.
 * Assumes each bit settles between edges seen by the second stage.
 */
`timescale 1ns/100ps
`default_nettype none
module tsf_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad_width
		$error("tsf_sync width must be positive");
	end

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : tsf_sync
`default_nettype wire

// ---- src/tsf_parity.sv ----
/*
 * Parity generator and checker for one tape character.
 * Character is six data bits plus parity in bit 6; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
module tsf_parity #(
	parameter int W = 6
) (
	input wire logic even_mode,
	input wire logic [W-1:0] wr_data,
	input wire logic [W:0] rd_char,
	output logic wr_par,
	output logic rd_err
);
	if (W < 1) begin : g_bad_width
		$error("tsf_parity width must be positive");
	end

	// Odd mode makes the total count of ones odd, even mode even
	assign wr_par = (^wr_data) ^ ~even_mode;
	assign rd_err = (^rd_char) ^ ~even_mode;
endmodule : tsf_parity
`default_nettype wire

// ---- src/tsf_decoder.sv ----
/*
 * Tape synchronizer function decoder and status responder.
 * The host I/O channel is seen as APB registers: function word, data
 * word, two status words, unit select setting and state. The tape
 * handler pins are asynchronous and are synchronized before use.
 */
`timescale 1ns/100ps
`default_nettype none
module tsf_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tsf_pkg::tsf_tape_in_s tape_in,
	output tsf_pkg::tsf_tape_out_s tape_out,
	output logic sync_irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tsf_pkg::tsf_tape_in_s tin, tin_prev_r;
	tsf_pkg::tsf_state_e state_r;
	tsf_pkg::tsf_src_e src_r;
	logic [5:0] op_r, rx_r, fop;
	logic [1:0] unit_r;
	logic lock_r, coded_r, dens_r, perr_r, prog_r, bcd_r, eof_r, done_r;
	logic setup, access, wr_func, wr_data, mapped, selected;
	logic fop_write, fop_read, fop_move, known_op, move_end;
	logic strobe_rise, mark_rise, gap_rise, lp_rise;
	logic par_bit, rd_par_err, bcd_bad;
	logic [11:0] fcode;
	logic [7:0] stat1, stat2;
	logic [31:0] rdata_nxt;

	// ----------------------------------------------------------------
	// Tape handler pin synchronizers
	// ----------------------------------------------------------------
	tsf_sync #(.W($bits(tsf_pkg::tsf_tape_in_s))) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(tape_in),
		.q(tin)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tin_prev_r <= '0;
		end else begin
			tin_prev_r <= tin;
		end
	end

	assign strobe_rise = tin.char_strobe & ~tin_prev_r.char_strobe;
	assign mark_rise = tin.file_mark & ~tin_prev_r.file_mark;
	assign gap_rise = tin.rec_gap & ~tin_prev_r.rec_gap;
	assign lp_rise = tin.load_point & ~tin_prev_r.load_point;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign setup = psel & ~penable;
	assign access = psel & penable;

	always_comb begin
		if ((paddr == tsf_pkg::ADDR_FUNC) | (paddr == tsf_pkg::ADDR_DATA)
			| (paddr == tsf_pkg::ADDR_STAT1) | (paddr == tsf_pkg::ADDR_STAT2)) begin
			mapped = 1'b1;
		end else if ((paddr == tsf_pkg::ADDR_UNIT) | (paddr == tsf_pkg::ADDR_STATE)) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	assign pslverr = access & ~mapped;
	assign wr_func = access & pwrite & (paddr == tsf_pkg::ADDR_FUNC);
	assign wr_data = access & pwrite & (paddr == tsf_pkg::ADDR_DATA);

	// ----------------------------------------------------------------
	// Function code decode
	// ----------------------------------------------------------------
	assign fcode = pwdata[11:0];
	assign fop = fcode[5:0];
	// Unit digit must match the handler's unit setting, units 0-3 only
	assign selected = wr_func
		& (fcode[tsf_pkg::GROUP_LSB +: 3] == tsf_pkg::GROUP_TAPE)
		& (fcode[tsf_pkg::UNIT_LSB +: 3] <= tsf_pkg::UNIT_MAX)
		& (fcode[tsf_pkg::UNIT_LSB +: 2] == unit_r);
	assign fop_write = (fop[5:2] == tsf_pkg::OP_WRITE_HI);
	assign fop_read = (fop[5:2] == tsf_pkg::OP_READ_HI)
		| (fop == tsf_pkg::OP_READ_KEEP);
	assign fop_move = (fop == tsf_pkg::OP_SRCH_FWD) | (fop == tsf_pkg::OP_SRCH_BACK)
		| (fop == tsf_pkg::OP_REWIND) | (fop == tsf_pkg::OP_UNLOAD)
		| (fop == tsf_pkg::OP_REC_FWD) | (fop == tsf_pkg::OP_REC_BACK);
	assign known_op = fop_write | fop_read | fop_move
		| (fop == tsf_pkg::OP_MARK) | (fop == tsf_pkg::OP_STAT1)
		| (fop == tsf_pkg::OP_STAT2) | (fop == tsf_pkg::OP_LOCK_SET)
		| (fop == tsf_pkg::OP_LOCK_CLR) | (fop == tsf_pkg::OP_CLEAR);

	// ----------------------------------------------------------------
	// Unit select setting and interrupt lockout
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_r <= tsf_pkg::UNIT_RESET;
		end else if (access & pwrite & (paddr == tsf_pkg::ADDR_UNIT)) begin
			unit_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= tsf_pkg::LOCK_RESET;
		end else if (selected & (fop == tsf_pkg::OP_LOCK_SET)) begin
			lock_r <= 1'b1;
		end else if (selected & (fop == tsf_pkg::OP_LOCK_CLR)) begin
			lock_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Mode: density and parity, kept by status and plain read
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coded_r <= tsf_pkg::CODED_RESET;
			dens_r <= tsf_pkg::DENS_RESET;
		end else if (selected & (fop_write | (fop_read & (fop != tsf_pkg::OP_READ_KEEP)))) begin
			dens_r <= fop[tsf_pkg::MODE_DENS_BIT];
			coded_r <= fop[tsf_pkg::MODE_CODED_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	// Motion ends on the handler event that matches the held operation
	always_comb begin
		case (op_r)
			tsf_pkg::OP_SRCH_FWD: move_end = mark_rise | tin.end_tape;
			tsf_pkg::OP_SRCH_BACK: move_end = mark_rise | lp_rise;
			tsf_pkg::OP_REWIND: move_end = lp_rise;
			tsf_pkg::OP_UNLOAD: move_end = ~tin.ready;
			tsf_pkg::OP_REC_FWD: move_end = gap_rise | tin.end_tape;
			tsf_pkg::OP_REC_BACK: move_end = gap_rise | lp_rise;
			default: move_end = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= tsf_pkg::TSF_IDLE;
			op_r <= '0;
		end else if (selected & (fop == tsf_pkg::OP_CLEAR)) begin
			state_r <= tsf_pkg::TSF_IDLE;
		end else if (selected & fop_write) begin
			state_r <= tsf_pkg::TSF_WRITE;
			op_r <= fop;
		end else if (selected & fop_read) begin
			state_r <= tsf_pkg::TSF_READ;
			op_r <= fop;
		end else if (selected & fop_move) begin
			state_r <= tsf_pkg::TSF_MOVE;
			op_r <= fop;
		end else if (selected & (fop == tsf_pkg::OP_MARK)) begin
			state_r <= tsf_pkg::TSF_MARK;
			op_r <= fop;
		end else begin
			case (state_r)
				tsf_pkg::TSF_READ: if (gap_rise | tin.end_tape) state_r <= tsf_pkg::TSF_IDLE;
				tsf_pkg::TSF_MOVE: if (move_end) state_r <= tsf_pkg::TSF_IDLE;
				tsf_pkg::TSF_MARK: if (mark_rise) state_r <= tsf_pkg::TSF_IDLE;
				tsf_pkg::TSF_WRITE: if (tin.end_tape | ~tin.ready) state_r <= tsf_pkg::TSF_IDLE;
				default: state_r <= tsf_pkg::TSF_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Character path with parity
	// ----------------------------------------------------------------
	tsf_parity #(.W(6)) u_parity (
		.even_mode(coded_r),
		.wr_data(pwdata[5:0]),
		.rd_char(tin.rd_char),
		.wr_par(par_bit),
		.rd_err(rd_par_err)
	);

	assign bcd_bad = coded_r & (pwdata[5:0] == tsf_pkg::BCD_ILLEGAL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_r <= '0;
		end else if (strobe_rise & (state_r == tsf_pkg::TSF_READ)) begin
			rx_r <= tin.rd_char[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Sticky status flags: a new function code clears, events win
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			perr_r <= 1'b0;
			prog_r <= 1'b0;
			bcd_r <= 1'b0;
			eof_r <= 1'b0;
		end else begin
			if ((strobe_rise & (state_r == tsf_pkg::TSF_READ) & rd_par_err)
				| (wr_data & (state_r == tsf_pkg::TSF_WRITE) & bcd_bad)) begin
				perr_r <= 1'b1;
			end else if (selected) begin
				perr_r <= 1'b0;
			end
			if ((wr_data & (state_r != tsf_pkg::TSF_WRITE))
				| (wr_data & bcd_bad) | (selected & ~known_op)) begin
				prog_r <= 1'b1;
			end else if (selected) begin
				prog_r <= 1'b0;
			end
			if (wr_data & (state_r == tsf_pkg::TSF_WRITE) & bcd_bad) begin
				bcd_r <= 1'b1;
			end else if (selected) begin
				bcd_r <= 1'b0;
			end
			if (mark_rise & ((state_r == tsf_pkg::TSF_MOVE)
				| (state_r == tsf_pkg::TSF_READ))) begin
				eof_r <= 1'b1;
			end else if (selected) begin
				eof_r <= 1'b0;
			end
		end
	end

	// Set in any busy state on move_end, a record gap or a file mark unless a move code is taken that cycle, raised to the host unless locked out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
		end else if ((state_r != tsf_pkg::TSF_IDLE) & ~(selected & fop_move)
			& (move_end | gap_rise | mark_rise)) begin
			done_r <= 1'b1;
		end else if (selected) begin
			done_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_irq <= 1'b0;
		end else begin
			sync_irq <= done_r & ~lock_r;
		end
	end

	// ----------------------------------------------------------------
	// Status words
	// ----------------------------------------------------------------
	always_comb begin
		stat1 = '0;
		stat1[tsf_pkg::S1_CODED] = coded_r | bcd_r;
		stat1[tsf_pkg::S1_NOT_READY] = ~tin.ready;
		stat1[tsf_pkg::S1_PARITY] = perr_r;
		stat1[tsf_pkg::S1_PROGRAM] = prog_r;
		stat1[tsf_pkg::S1_EOF] = eof_r;
		stat1[tsf_pkg::S1_TAPE_MARK] = tin.load_point | tin.end_tape;
		stat1[tsf_pkg::S1_HIGH_DENS] = dens_r;
		stat1[tsf_pkg::S1_BUSY] = (state_r != tsf_pkg::TSF_IDLE);
		stat2 = '0;
		stat2[tsf_pkg::S2_HIGH_DENS] = dens_r;
		stat2[tsf_pkg::S2_EVEN] = coded_r;
		stat2[tsf_pkg::S2_EOF] = eof_r;
		stat2[tsf_pkg::S2_LOAD_POINT] = tin.load_point;
		stat2[tsf_pkg::S2_WR_NOT_READY] = ~tin.ready | ~tin.write_ring;
		stat2[tsf_pkg::S2_SEARCHING] = (state_r == tsf_pkg::TSF_MOVE)
			& ((op_r == tsf_pkg::OP_SRCH_FWD) | (op_r == tsf_pkg::OP_SRCH_BACK));
		stat2[tsf_pkg::S2_WR_MARK] = (state_r == tsf_pkg::TSF_MARK);
	end

	// A status request steers data reads until the next accepted code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r <= tsf_pkg::TSF_SRC_DATA;
		end else if (selected & (fop == tsf_pkg::OP_STAT1)) begin
			src_r <= tsf_pkg::TSF_SRC_STAT1;
		end else if (selected & (fop == tsf_pkg::OP_STAT2)) begin
			src_r <= tsf_pkg::TSF_SRC_STAT2;
		end else if (selected) begin
			src_r <= tsf_pkg::TSF_SRC_DATA;
		end
	end

	// ----------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = '0;
		if (paddr == tsf_pkg::ADDR_DATA) begin
			case (src_r)
				tsf_pkg::TSF_SRC_STAT1: rdata_nxt = {24'h000000, stat1};
				tsf_pkg::TSF_SRC_STAT2: rdata_nxt = {24'h000000, stat2};
				default: rdata_nxt = {26'h0000000, rx_r};
			endcase
		end else if (paddr == tsf_pkg::ADDR_STAT1) begin
			rdata_nxt = {24'h000000, stat1};
		end else if (paddr == tsf_pkg::ADDR_STAT2) begin
			rdata_nxt = {24'h000000, stat2};
		end else if (paddr == tsf_pkg::ADDR_UNIT) begin
			rdata_nxt = {30'h00000000, unit_r};
		end else if (paddr == tsf_pkg::ADDR_STATE) begin
			rdata_nxt = {26'h0000000, src_r, lock_r, state_r};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup & ~pwrite) begin
			prdata <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Tape handler commands
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tape_out <= '0;
		end else begin
			// Character fields share this process so the port has one driver
			tape_out.wr_valid <= wr_data & (state_r == tsf_pkg::TSF_WRITE);
			if (wr_data & (state_r == tsf_pkg::TSF_WRITE)) begin
				tape_out.wr_char <= {par_bit, pwdata[5:0]};
			end
			tape_out.fwd <= (state_r == tsf_pkg::TSF_READ) | (state_r == tsf_pkg::TSF_WRITE)
				| (state_r == tsf_pkg::TSF_MARK) | ((state_r == tsf_pkg::TSF_MOVE)
				& ((op_r == tsf_pkg::OP_SRCH_FWD) | (op_r == tsf_pkg::OP_REC_FWD)));
			tape_out.rev <= (state_r == tsf_pkg::TSF_MOVE)
				& ((op_r == tsf_pkg::OP_SRCH_BACK) | (op_r == tsf_pkg::OP_REC_BACK));
			tape_out.write <= (state_r == tsf_pkg::TSF_WRITE);
			tape_out.rewind <= (state_r == tsf_pkg::TSF_MOVE) & (op_r == tsf_pkg::OP_REWIND);
			tape_out.unload <= (state_r == tsf_pkg::TSF_MOVE) & (op_r == tsf_pkg::OP_UNLOAD);
			tape_out.mark <= (state_r == tsf_pkg::TSF_MARK);
			tape_out.high_density <= dens_r;
			tape_out.even_parity <= coded_r;
		end
	end

endmodule : tsf_decoder
`default_nettype wire

// ---- testbench/tsf_decoder_chk.sv ----
/* Port checker of the tape function decoder.
   Assumes the package map and one clock; bound into tsf_decoder. */
`timescale 1ns/100ps
`default_nettype none
module tsf_decoder_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire tsf_pkg::tsf_tape_out_s tape_out,
	input wire logic sync_irq
);
	logic [1:0] unit_r;
	logic [2:0] pw1, pw2;
	logic wr, fw, lock_r;
	logic [5:0] op;
	logic [7:0] mot;
	assign wr = psel && penable && pwrite;
	assign op = pwdata[5:0];
	assign fw = wr && paddr == 8'h00 && pwdata[11:6] == {3'h1, 1'b0, unit_r};
	assign mot = tape_out[15:8];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) unit_r <= 2'h0;
		else if (wr && paddr == 8'h10) unit_r <= pwdata[1:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lock_r <= 1'b0;
		else if (fw && op[5:1] == 5'h02) lock_r <= !op[0];
	end
	// Code bits lined up with outputs two edges after the code is taken
	always_ff @(posedge pclk) begin
		pw1 <= pwdata[2:0];
		pw2 <= pw1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cmd(logic [5:0] o);
		fw && op == o;
	endsequence
	a_write_mode: assert property (fw && op[5:2] == 4'h2 |-> ##2 tape_out.write
		&& tape_out.fwd && mot[1:0] == {pw2[0], pw2[1]}) else $error("write start wrong");
	a_read_mode: assert property (fw && op[5:2] == 4'h6 |-> ##2 !tape_out.write
		&& tape_out.fwd && mot[1:0] == {pw2[0], pw2[1]}) else $error("read start wrong");
	a_mark_cmd: assert property (s_cmd(6'h0C) |-> ##2 tape_out.mark)
		else $error("no file mark");
	a_move_dir: assert property (fw && (op[5:1] == 5'h08 || op[5:1] == 5'h0A) |-> ##2
		tape_out.rev == pw2[0] && tape_out.fwd != tape_out.rev) else $error("bad direction");
	a_rewind_kind: assert property (fw && op[5:3] == 3'h2 && op[1:0] == 2'h2 |-> ##2
		tape_out.unload == pw2[2] && mot[4:3] != 2'h0) else $error("bad rewind");
	a_clear_idle: assert property (s_cmd(6'h07) |-> ##2 mot[7:2] == 6'h00)
		else $error("clear left motion");
	a_lock_quiet: assert property (lock_r && $past(lock_r) |-> !sync_irq)
		else $error("irq under lockout");
	a_unit_guard: assert property (wr && paddr == 8'h00 && pwdata[8:6] != {1'b0, unit_r}
		|-> ##1 $stable(mot) [*2]) else $error("foreign unit acted");
	a_wr_parity: assert property (tape_out.wr_valid |-> ^tape_out.wr_char != mot[0])
		else $error("bad write parity");
endmodule : tsf_decoder_chk
bind tsf_decoder tsf_decoder_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tape_out(tape_out),
	.sync_irq(sync_irq));
`default_nettype wire

// ---- testbench/tsf_tape_model.sv ----
/* Tape handler model: dly cycles into a motion it sends a character,
   then a record gap with file mark or load point. Assumes one clock. */
`timescale 1ns/100ps
`default_nettype none
module tsf_tape_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] dly,
	input wire logic fm,
	input wire logic bad_par,
	input wire tsf_pkg::tsf_tape_out_s to,
	output tsf_pkg::tsf_tape_in_s ti
);
	logic [4:0] cnt_r;
	logic run, stop;
	assign run = to.fwd || to.rev || to.rewind || to.mark;
	assign stop = run && cnt_r == 5'(dly) + 5'h04;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ti <= '0;
			cnt_r <= 5'h00;
		end else begin
			cnt_r <= run ? cnt_r + 5'h01 : 5'h00;
			// Unload takes the transport off line at once
			ti.ready <= !to.unload;
			ti.write_ring <= 1'b1;
			ti.char_strobe <= run && cnt_r == 5'(dly);
			ti.rd_char <= {to.even_parity ^ bad_par, 6'h15};
			ti.rec_gap <= stop;
			ti.file_mark <= stop && (fm || to.mark);
			// Load point is a level: it stays until forward motion leaves it
			ti.load_point <= stop && to.rewind || ti.load_point && !(to.fwd && !to.rewind);
		end
	end
endmodule : tsf_tape_model
`default_nettype wire

// ---- testbench/tape_sync_function_decoder_test.sv ----
/* Bench of the tape function decoder: APB host tasks send codes and
   data and read status. Assumes the tape handler model beside it. */
`timescale 1ns/100ps
`default_nettype none
module tape_sync_function_decoder_test;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic fm = 1'b0, bad_par = 1'b0, buf_busy = 1'b0, pready, pslverr, err, sync_irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] dly = 4'h2;
	logic [1:0] unit = 2'h2;
	tsf_pkg::tsf_tape_in_s tape_in;
	tsf_pkg::tsf_tape_out_s tape_out;
	// Motion code, then the status one and two bits it leaves
	logic [23:0] mv [5] = '{24'h122008, 24'h140000, 24'h101004, 24'h150000, 24'h111004};
	int error_cnt = 0, compares = 0, cyc = 0;
	always #2.5 pclk = ~pclk;
	tsf_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tape_in(tape_in), .tape_out(tape_out), .sync_irq(sync_irq));
	tsf_tape_model model_u (.clk(pclk), .rst_n(presetn), .dly(dly), .fm(fm),
		.bad_par(bad_par), .to(tape_out), .ti(tape_in));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task fn(input logic [5:0] op);
		apb(1'b1, 8'h00, {20'h0, 3'h1, 1'b0, unit, op});
	endtask : fn
	// Buffered host output: consecutive words up to, not including, last
	task start_buffered_output(input logic [5:0] first, input logic [5:0] last);
		if (!buf_busy) begin
			buf_busy = 1'b1;
			for (logic [5:0] a = first; a != last; a++) begin
				apb(1'b1, 8'h04, {26'h0, a});
			end
			buf_busy = 1'b0;
		end
	endtask : start_buffered_output
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk
	task wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h14, 32'h0);
			n++;
		end while (rd[2:0] !== 3'h0 && n < 300);
		chk({29'h0, rd[2:0]}, 32'h0);
		// The interrupt level lands one edge after the state goes idle
		repeat (2) @(posedge pclk);
	endtask : wait_idle
	task wrap_up;
		$display("error_cnt %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up;
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rchk(8'h08, 32'h0);
		rchk(8'h0C, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, 8'h10, {30'h0, unit});
		apb(1'b1, 8'h00, 32'h249);
		apb(1'b1, 8'h00, 32'h389);
		rchk(8'h14, 32'h0);
		for (int m = 0; m < 4; m++) begin
			fn(6'h08 + 6'(m));
			apb(1'b1, 8'h04, 32'h15);
			rchk(8'h08, {24'h0, 1'b1, m[0], 5'h0, m[1]});
			rchk(8'h0C, 32'(m));
		end
		start_buffered_output(6'h01, 6'h04);
		rchk(8'h08, 32'hC1);
		fn(6'h0A);
		apb(1'b1, 8'h04, 32'h0);
		rchk(8'h08, 32'h8D);
		fn(6'h07);
		rchk(8'h14, 32'h0);
		apb(1'b1, 8'h04, 32'h15);
		rchk(8'h08, 32'h09);
		fn(6'h02);
		rchk(8'h04, 32'h01);
		fn(6'h03);
		rchk(8'h04, 32'h02);
		bad_par <= 1'b1;
		fn(6'h18);
		wait_idle;
		rchk(8'h08, 32'h04);
		bad_par <= 1'b0;
		fn(6'h1B);
		wait_idle;
		rchk(8'h04, 32'h15);
		fn(6'h1C);
		wait_idle;
		rchk(8'h08, 32'h41);
		foreach (mv[i]) begin
			fm <= mv[i][2];
			fn(mv[i][21:16]);
			wait_idle;
			rchk(8'h08, {24'h0, mv[i][15:8] | 8'h41});
			rchk(8'h0C, {24'h0, mv[i][7:0] | 8'h03});
			chk({31'h0, sync_irq}, 32'h1);
		end
		fm <= 1'b0;
		dly <= 4'hF;
		fn(6'h04);
		fn(6'h14);
		wait_idle;
		chk({31'h0, sync_irq}, 32'h0);
		rchk(8'h14, 32'h08);
		fn(6'h05);
		fn(6'h15);
		wait_idle;
		chk({31'h0, sync_irq}, 32'h1);
		fn(6'h0C);
		rchk(8'h0C, 32'h43);
		wait_idle;
		fn(6'h16);
		wait_idle;
		fn(6'h01);
		rchk(8'h08, 32'h49);
		wrap_up;
	end
endmodule : tape_sync_function_decoder_test
`default_nettype wire
